// [logic/fss_regs.svh]
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH
// Duty cycle is carried in whole percent, 0 to 100.
`define FSS_DUTY_START      7'h19
`define FSS_DUTY_STEP       7'h05
`define FSS_DUTY_END        7'h32
`define FSS_DUTY_FULL       7'h64
`define FSS_STEP_TIME_MS    100
`define FSS_MAX_START_MS    3000
`define FSS_CLK_KHZ         40000
`define FSS_STEP_CYCLES     (`FSS_STEP_TIME_MS * `FSS_CLK_KHZ)
`define FSS_MAX_CYCLES      (`FSS_MAX_START_MS * `FSS_CLK_KHZ)
`define FSS_MIN_SPEED_SETTING_FULL      5'h1F
`define FSS_ZERO_BAND0      7'h00
`define FSS_ZERO_BAND1      7'h0A
`define FSS_ZERO_BAND2      7'h14
`define FSS_ZERO_BAND3      7'h1E
`endif

// [logic/fss_pkg.sv]
`default_nettype none
package fss_pkg;
    typedef enum logic [1:0] {
        FSS_IDLE  = 2'b00,
        FSS_START = 2'b01,
        FSS_CHECK = 2'b10,
        FSS_RUN   = 2'b11
    } fss_state_e;
    typedef logic [6:0] fss_duty_t;
endpackage
`default_nettype wire

// [logic/fss_curve.sv]
`include "fss_regs.svh"
`default_nettype none
module fss_curve
    import fss_pkg::*;
(
    input  wire logic [3:0] slope_thresholds,
    input  wire logic       pwm_in_low,
    input  wire fss_duty_t  pwm_duty,
    input  wire logic [4:0] min_speed_setting,
    output fss_duty_t       duty_out
);
    fss_duty_t zero_duty;
    fss_duty_t min_duty;
    logic [13:0] min_prod;
    logic [13:0] span;
    fss_duty_t scaled;

    // Highest tripped comparator wins; thermometer code from the reference current bands.
    always_comb begin
        if (slope_thresholds[3]) begin
            zero_duty = `FSS_ZERO_BAND3;
        end else if (slope_thresholds[2]) begin
            zero_duty = `FSS_ZERO_BAND2;
        end else if (slope_thresholds[1]) begin
            zero_duty = `FSS_ZERO_BAND1;
        end else begin
            zero_duty = `FSS_ZERO_BAND0;
        end
    end

    // 32 levels of about 3 percent each.
    // The product needs 12 bits; a 7-bit product would wrap above code 1.
    assign min_prod = {9'h000, min_speed_setting} * 14'h0064;
    assign min_duty = 7'(min_prod / 14'h001F);

    always_comb begin
        span   = 14'h0000;
        scaled = 7'h00;
        if (min_speed_setting == `FSS_MIN_SPEED_SETTING_FULL) begin
            duty_out = `FSS_DUTY_FULL;
        end else if (pwm_in_low) begin
            duty_out = min_duty;
        end else begin
            if (pwm_duty > zero_duty) begin
                span   = {7'h00, 7'(pwm_duty - zero_duty)} * 14'h0064;
                scaled = 7'(span / {7'h00, 7'(7'h64 - zero_duty)});
            end
            duty_out = (scaled > min_duty) ? scaled : min_duty;
        end
    end
endmodule // fss_curve
`default_nettype wire

// [logic/fss_core.sv]
// Operation
// - Soft start begins at 25% duty, adds 5% every 100 ms, stops at 50%.
// - Soft start lasts at most 3 s before the speed check.
// - During soft start the pulse-width command and minimum-speed setting are ignored.
// - Gain adaptation runs throughout soft start and must settle before normal run.
// - At soft start end, speed met and gain settled leads to sine operation.
// - Speed not met at soft start end restarts the start-up until met.
// - Four slope comparators select zero-speed input duty 0, 10, 20 or 30%.
// - Pulse-width input held low makes minimum-speed voltage the sole speed command.
// - Minimum-speed setting is quantized into 32 levels, about 3% each.
// - Full-scale minimum-speed setting drives full speed regardless of pulse width.
`include "fss_regs.svh"
`default_nettype none
module fss_core
    import fss_pkg::*;
#(
    parameter int STEP_CYCLES = `FSS_STEP_CYCLES,
    parameter int MAX_CYCLES  = `FSS_MAX_CYCLES
)(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       enable,
    input  wire logic       speed_ok,
    input  wire logic       gain_settled,
    input  wire logic [3:0] slope_thresholds,
    input  wire logic       pwm_in_low,
    input  wire fss_duty_t  pwm_duty,
    input  wire logic [4:0] min_speed_setting,
    output fss_duty_t       duty_out,
    output logic            soft_start_active,
    output logic            gain_adapt_en,
    output logic            sine_vector_modulation,
    output logic            restart_pulse
);
    // ------------------------------------------------------------
    // Speed curve for normal running
    // ------------------------------------------------------------
    fss_duty_t   run_duty;

    fss_curve u_curve (
        .slope_thresholds  (slope_thresholds),
        .pwm_in_low        (pwm_in_low),
        .pwm_duty          (pwm_duty),
        .min_speed_setting (min_speed_setting),
        .duty_out          (run_duty)
    );

    // ------------------------------------------------------------
    // Start sequencer
    // ------------------------------------------------------------
    fss_state_e  state_reg,    state_next;
    logic        restart_reg,  restart_next;
    // Counters are 32 bits so the full start budget at the real clock rate fits.
    logic [31:0] step_cnt_reg, step_cnt_next;
    logic [31:0] time_cnt_reg, time_cnt_next;
    fss_duty_t   ramp_reg,     ramp_next;
    fss_duty_t   duty_reg,     duty_next;
    logic        start_load;
    logic        step_done;
    logic        start_done;

    // Every start attempt, first or repeated, reloads the ramp and both timers.
    assign start_load = (state_next == FSS_START) && (state_reg != FSS_START);
    assign step_done  = (step_cnt_reg == 32'(STEP_CYCLES - 1));
    assign start_done = (time_cnt_reg == 32'(MAX_CYCLES - 1));

    always_comb begin
        state_next   = state_reg;
        restart_next = 1'b0;
        case (state_reg)
            FSS_IDLE: begin
                if (enable) begin
                    state_next = FSS_START;
                end
            end
            FSS_START: begin
                if (start_done) begin
                    state_next = FSS_CHECK;
                end
            end
            FSS_CHECK: begin
                if (!speed_ok) begin
                    // Restart from scratch so the inrush limit applies again.
                    state_next   = FSS_START;
                    restart_next = 1'b1;
                end else if (gain_settled) begin
                    state_next = FSS_RUN;
                end
            end
            FSS_RUN: begin
                // Running holds until the run request drops; stall protection lives elsewhere.
                state_next = FSS_RUN;
            end
            default: begin
                state_next = FSS_IDLE;
            end
        endcase
        // Dropping the run request wins over every other transition.
        if (!enable) begin
            state_next   = FSS_IDLE;
            restart_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg   <= FSS_IDLE;
            restart_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            restart_reg <= restart_next;
        end
    end

    // ------------------------------------------------------------
    // Step and start-phase timers
    // ------------------------------------------------------------
    // The timers advance only in the start state, so waiting for gain costs no start budget.
    always_comb begin
        step_cnt_next = step_cnt_reg;
        time_cnt_next = time_cnt_reg;
        if (start_load) begin
            step_cnt_next = 32'h00000000;
            time_cnt_next = 32'h00000000;
        end else if (state_reg == FSS_START) begin
            time_cnt_next = time_cnt_reg + 32'h00000001;
            if (step_done) begin
                step_cnt_next = 32'h00000000;
            end else begin
                step_cnt_next = step_cnt_reg + 32'h00000001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            step_cnt_reg <= 32'h00000000;
            time_cnt_reg <= 32'h00000000;
        end else begin
            step_cnt_reg <= step_cnt_next;
            time_cnt_reg <= time_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Duty ramp and output duty
    // ------------------------------------------------------------
    always_comb begin
        ramp_next = ramp_reg;
        if (start_load) begin
            ramp_next = `FSS_DUTY_START;
        end else if ((state_reg == FSS_START) && step_done && (ramp_reg < `FSS_DUTY_END)) begin
            ramp_next = ramp_reg + `FSS_DUTY_STEP;
        end
    end

    // Check state holds the final ramp duty while waiting for gain to settle.
    always_comb begin
        case (state_next)
            FSS_RUN: begin
                duty_next = run_duty;
            end
            FSS_IDLE: begin
                duty_next = 7'h00;
            end
            default: begin
                duty_next = ramp_next;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ramp_reg <= 7'h00;
            duty_reg <= 7'h00;
        end else begin
            ramp_reg <= ramp_next;
            duty_reg <= duty_next;
        end
    end

    // ------------------------------------------------------------
    // Registered status outputs
    // ------------------------------------------------------------
    logic ss_reg;
    logic ss_next;
    logic gain_reg;
    logic gain_next;
    logic sine_reg;
    logic sine_next;

    // Flags decode the next state so they change on the same edge as the duty.
    always_comb begin
        ss_next   = (state_next == FSS_START);
        gain_next = (state_next == FSS_START) || (state_next == FSS_CHECK);
        sine_next = (state_next == FSS_RUN);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ss_reg   <= 1'b0;
            gain_reg <= 1'b0;
            sine_reg <= 1'b0;
        end else begin
            ss_reg   <= ss_next;
            gain_reg <= gain_next;
            sine_reg <= sine_next;
        end
    end

    // ------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------
    assign duty_out               = duty_reg;
    assign soft_start_active      = ss_reg;
    assign gain_adapt_en          = gain_reg;
    assign sine_vector_modulation = sine_reg;
    assign restart_pulse          = restart_reg;
endmodule // fss_core
`default_nettype wire

// [test/fss_fan_model.sv]
`default_nettype none
module fss_fan_model
    import fss_pkg::*;
(
    input  wire logic       spin_ok,
    input  wire fss_duty_t  duty_out,
    input  wire logic [4:0] min_cmd,
    output logic            speed_ok,
    output logic [4:0]      min_speed_setting
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Fan and speed source
    // ----
    // An undriven coil never reaches speed, so a stall cannot be hidden.
    assign speed_ok = spin_ok && duty_out != 7'h00;
    // A 5-bit code cannot leave the 0 to 2.5 V span.
    assign min_speed_setting = min_cmd;
endmodule // fss_fan_model
`default_nettype wire

// [test/fss_core_sva.sv]
`default_nettype none
module fss_core_sva
    import fss_pkg::*;
#(parameter int MAX_CYCLES = 80)(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       speed_ok,
    input wire logic       gain_settled,
    input wire logic       pwm_in_low,
    input wire logic [4:0] min_speed_setting,
    input wire fss_duty_t  duty_out,
    input wire logic       soft_start_active,
    input wire logic       gain_adapt_en,
    input wire logic       sine_vector_modulation,
    input wire logic       restart_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Start-up and run checks
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    int ss_cnt;
    always_ff @(posedge clk) ss_cnt <= (sys_rst || !soft_start_active) ? 0 : ss_cnt + 1;
    sequence s_enter; !soft_start_active ##1 soft_start_active; endsequence
    sequence s_reload; soft_start_active && duty_out == 7'h19; endsequence
    property p_start; s_enter |-> duty_out == 7'h19; endproperty
    a_start: assert property (p_start) else $error("bad first duty");
    property p_step; soft_start_active && $past(soft_start_active) |-> duty_out <= 7'h32 &&
        (duty_out == $past(duty_out) || duty_out == $past(duty_out) + 7'h05); endproperty
    a_step: assert property (p_step) else $error("bad ramp step");
    property p_len; soft_start_active |-> ss_cnt < MAX_CYCLES; endproperty
    a_len: assert property (p_len) else $error("start too long");
    property p_gain; soft_start_active |-> gain_adapt_en; endproperty
    a_gain: assert property (p_gain) else $error("gain not adapting");
    property p_sine; $rose(sine_vector_modulation) |-> $past(speed_ok) && $past(gain_settled); endproperty
    a_sine: assert property (p_sine) else $error("early sine run");
    property p_restart; restart_pulse |-> ##[0:1] s_reload; endproperty
    a_restart: assert property (p_restart) else $error("bad restart");
    property p_full; sine_vector_modulation && $past(sine_vector_modulation) &&
        $past(min_speed_setting) == 5'h1F |-> duty_out == 7'h64; endproperty
    a_full: assert property (p_full) else $error("not full speed");
    property p_analog; sine_vector_modulation && $past(sine_vector_modulation) && $past(pwm_in_low)
        |-> duty_out == 7'($past(min_speed_setting) * 100 / 31); endproperty
    a_analog: assert property (p_analog) else $error("bad analog duty");
endmodule // fss_core_sva
`default_nettype wire

// [test/tb.sv]
`default_nettype none
module tb
    import fss_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Bench
    // ----
    logic       clk = 0, sys_rst = 1, enable = 0, spin_ok = 0, gain_settled = 0, pwm_in_low = 0;
    logic [3:0] slope_thresholds = 4'h0;
    logic [4:0] min_cmd = 5'h00, min_speed_setting;
    fss_duty_t  pwm_duty = 7'h00, duty_out;
    logic       speed_ok, ss, gae, svm, rp;
    int         n_fail = 0, check_count = 0;
    always #12.5 clk = ~clk;
    fss_core #(.STEP_CYCLES(10), .MAX_CYCLES(80)) dut (.clk, .sys_rst, .enable, .speed_ok, .gain_settled,
        .slope_thresholds, .pwm_in_low, .pwm_duty, .min_speed_setting, .duty_out, .soft_start_active(ss),
        .gain_adapt_en(gae), .sine_vector_modulation(svm), .restart_pulse(rp));
    fss_fan_model fan (.spin_ok, .duty_out, .min_cmd, .speed_ok, .min_speed_setting);
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // Waits are bounded so a stuck state machine ends the run instead of hanging it.
    task automatic wait_on(int sel, string what);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if ((sel == 0 ? ss : sel == 1 ? rp : svm) === 1'b1) begin
                chk(what, 8'h01, 8'h01);
                return;
            end
        end
        chk(what, 8'h01, 8'h00);
        tally_and_finish();
    endtask
    function automatic logic [7:0] exp_run(logic [3:0] th, logic lo, logic [6:0] p, logic [4:0] mn);
        int m, z, q;
        m = mn * 100 / 31;
        z = th[3] ? 30 : th[2] ? 20 : th[1] ? 10 : 0;
        q = p > z ? (p - z) * 100 / (100 - z) : 0;
        if (mn == 5'h1F) return 8'h64;
        return 8'((lo || q < m) ? m : q);
    endfunction
    task automatic t_soft(bit restarted);
        // After a restart the start state is already showing when this task is entered.
        if (restarted) begin
            chk("restart start", 8'h01, {7'h00, ss});
        end else begin
            wait_on(0, "start");
        end
        for (int i = 0; i < 80; i++) begin
            chk("ramp", i < 50 ? 8'(25 + 5 * (i / 10)) : 8'h32, {1'b0, duty_out});
            chk("gain adapt", 8'h01, {7'h00, gae});
            @(negedge clk);
        end
        chk("start end", 8'h00, {7'h00, ss});
        $display("test soft start done");
    endtask
    task automatic set_run(logic [3:0] th, logic lo, logic [6:0] p, logic [4:0] mn);
        slope_thresholds = th;
        pwm_in_low = lo;
        pwm_duty = p;
        min_cmd = mn;
        repeat (2) @(negedge clk);
        chk("run duty", exp_run(th, lo, p, mn), {1'b0, duty_out});
    endtask
    task automatic t_curve();
        logic [3:0] th [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
        logic [6:0] pw [4] = '{7'h00, 7'h1E, 7'h41, 7'h64};
        for (int t = 0; t < 5; t++) begin
            for (int k = 0; k < 4; k++) begin
                set_run(th[t], 1'b0, pw[k], 5'h03);
            end
        end
        set_run(4'h3, 1'b1, 7'h64, 5'h0A);
        set_run(4'h0, 1'b0, 7'h00, 5'h1F);
        $display("test speed curve done");
    endtask
    initial begin
        repeat (4) @(negedge clk);
        sys_rst = 0;
        enable = 1;
        pwm_duty = 7'h64;
        pwm_in_low = 1;
        min_cmd = 5'h1F;
        t_soft(1'b0);
        wait_on(1, "restart");
        spin_ok = 1;
        t_soft(1'b1);
        repeat (4) @(negedge clk);
        chk("run early", 8'h00, {7'h00, svm});
        gain_settled = 1;
        wait_on(2, "sine run");
        chk("gain done", 8'h00, {7'h00, gae});
        t_curve();
        enable = 0;
        @(negedge clk);
        chk("off duty", 8'h00, {1'b0, duty_out});
        chk("off run", 8'h00, {7'h00, svm});
        tally_and_finish();
    end
endmodule // tb
bind fss_core fss_core_sva #(.MAX_CYCLES(MAX_CYCLES)) sva (.clk, .sys_rst, .speed_ok, .gain_settled, .pwm_in_low,
    .min_speed_setting, .duty_out, .soft_start_active, .gain_adapt_en, .sine_vector_modulation, .restart_pulse);
`default_nettype wire
